/* logic/jicl_params.svh */
// Constants for the test-port instruction cache loader.
// Assumes inclusion by the package and by design files by bare name.
`ifndef JICL_PARAMS_SVH
`define JICL_PARAMS_SVH

// Packet and field layout
`define JICL_PKT_W          33
`define JICL_PKT_MSB        32
`define JICL_PAR_BIT        32
`define JICL_WORD_W         32
`define JICL_FN_MSB         2
`define JICL_ADDR_LSB       6
`define JICL_ADDR_W         27
`define JICL_WIDX_W         3
`define JICL_LAST_WORD      3'h7

// Function codes in the low bits of a command packet
`define JICL_FN_INV_LINE    3'h0
`define JICL_FN_MINI_FLUSH  3'h1
`define JICL_FN_MAIN_WR     3'h2
`define JICL_FN_MINI_WR     3'h3

// Instruction register
`define JICL_IR_W           5
`define JICL_IR_CACHE_LOAD  5'h07
`define JICL_IR_IDCODE      5'h01
`define JICL_IR_DBG_SEL     5'h09

// Core restart address
`define JICL_RESET_VECTOR   32'h00000000

// Timing
`define JICL_MCLK_PERIOD_NS 100
`define JICL_TCK_PERIOD_NS  125
`define JICL_DRAIN_TCK      15
`define JICL_DRAIN_NS       (`JICL_DRAIN_TCK * `JICL_TCK_PERIOD_NS)
`define JICL_DRAIN_CYC      (`JICL_DRAIN_NS / `JICL_MCLK_PERIOD_NS)

// Crossing bundle positions
`define JICL_X_W            5
`define JICL_X_TGL          4
`define JICL_X_MODE         3
`define JICL_X_HOLD         2
`define JICL_X_HALT         1
`define JICL_X_PIN_N        0

`endif

/* logic/jicl_pkg.sv */
// Types shared by the loader modules.
// Assumes jicl_params.svh is on the include path.
`include "jicl_params.svh"

package jicl_pkg;

	typedef enum logic [0:0] {
		JICL_IDLE  = 1'b0,
		JICL_ISSUE = 1'b1
	} jicl_state_t;

	typedef struct packed {
		logic [`JICL_IR_W-1:0]  ir;
		logic [`JICL_PKT_MSB:0] cap_sr;
		logic [`JICL_PKT_MSB:0] hold_sr;
		logic                   upd_tgl;
		logic                   reset_hold;
		logic                   halt_mode;
		logic                   tdo;
	} jicl_tck_st_t;

	typedef struct packed {
		jicl_state_t              state;
		logic                     tgl_d;
		logic                     expect_data;
		logic                     mini_sel;
		logic [`JICL_WIDX_W-1:0]  word_idx;
		logic [`JICL_PKT_MSB:0]   core_sr;
		logic [`JICL_ADDR_W-1:0]  line_addr;
		logic                     inval_line;
		logic                     mini_flush;
		logic                     wr_main;
		logic                     wr_mini;
		logic [`JICL_WIDX_W-1:0]  wr_word;
		logic [`JICL_WORD_W-1:0]  wr_data;
		logic                     wr_par;
		logic                     core_rst;
		logic                     main_inval;
		logic                     mini_inval;
	} jicl_core_st_t;

endpackage : jicl_pkg

/* logic/jicl_sync.sv */
// Two-stage level synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a toggle; bits are not coherent.
`timescale 1ns/1ps

module jicl_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} jicl_sync_st_t;

	jicl_sync_st_t r_reg;
	jicl_sync_st_t r_next;

	always_comb begin
		r_next    = r_reg;
		r_next.s1 = d_i;
		r_next.s2 = r_reg.s1;
	end

	// Synchronous reset: reset value arrives as a steady tie-off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= {rst_val_i, rst_val_i};
		end else begin
			r_reg <= r_next;
		end
	end

	assign q_o = r_reg.s2;

endmodule : jicl_sync

/* logic/jicl_tck_side.sv */
// Test-clock side: instruction register, capture shift register, holding
// register and the debug-select fields. Assumes TAP state decodes on tck.
`timescale 1ns/1ps
`include "jicl_params.svh"

module jicl_tck_side (
	input  wire logic                   tck_i,
	input  wire logic                   test_rst_i,
	input  wire logic                   tdi_i,
	input  wire logic                   capture_dr_i,
	input  wire logic                   shift_dr_i,
	input  wire logic                   update_dr_i,
	input  wire logic                   ir_update_i,
	input  wire logic [`JICL_IR_W-1:0]  ir_value_i,
	input  wire logic                   dbg_hold_bit_i,
	input  wire logic                   dbg_halt_bit_i,
	output logic                        tdo_o,
	output logic                        load_mode_o,
	output logic                        reset_hold_o,
	output logic                        halt_mode_o,
	output logic                        upd_tgl_o,
	output logic [`JICL_PKT_MSB:0]      hold_data_o
);
	jicl_pkg::jicl_tck_st_t r_reg;
	jicl_pkg::jicl_tck_st_t r_next;
	logic                   load_sel;
	logic                   dbg_sel;

	assign load_sel = (r_reg.ir == `JICL_IR_CACHE_LOAD);
	assign dbg_sel  = (r_reg.ir == `JICL_IR_DBG_SEL);

	always_comb begin
		r_next = r_reg;
		if (ir_update_i) begin
			r_next.ir = ir_value_i;
		end
		// Capture leaves old contents in place
		if (load_sel && shift_dr_i) begin
			r_next.cap_sr = {tdi_i, r_reg.cap_sr[`JICL_PKT_MSB:1]};
		end
		if (load_sel && update_dr_i) begin
			r_next.hold_sr = r_reg.cap_sr;
			r_next.upd_tgl = ~r_reg.upd_tgl;
		end
		if (dbg_sel && update_dr_i) begin
			r_next.reset_hold = dbg_hold_bit_i;
			r_next.halt_mode  = dbg_halt_bit_i;
		end
		r_next.tdo = r_next.cap_sr[0];
	end

	always_ff @(posedge tck_i) begin
		if (test_rst_i) begin
			r_reg    <= '0;
			r_reg.ir <= `JICL_IR_IDCODE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tdo_o        = r_reg.tdo;
	assign load_mode_o  = load_sel;
	assign reset_hold_o = r_reg.reset_hold;
	assign halt_mode_o  = r_reg.halt_mode;
	assign upd_tgl_o    = r_reg.upd_tgl;
	assign hold_data_o  = r_reg.hold_sr;

	a_update_copy : assert property (@(posedge tck_i) disable iff (test_rst_i)
		(load_sel && update_dr_i) |=> (r_reg.hold_sr == $past(r_reg.cap_sr)))
		else $error("holding register missed update");

	a_capture_keeps : assert property (@(posedge tck_i) disable iff (test_rst_i)
		(capture_dr_i && !shift_dr_i) |=> (r_reg.cap_sr == $past(r_reg.cap_sr)))
		else $error("capture disturbed the shift register");

	a_test_reset_ir : assert property (@(posedge tck_i)
		test_rst_i |=> (r_reg.ir == `JICL_IR_IDCODE && !r_reg.halt_mode))
		else $error("test reset left modes set");

endmodule : jicl_tck_side

/* logic/jicl_top.sv */
// Test-port instruction cache loader: packet path into the caches and the
// core reset hold. Assumes a TAP controller on tck supplies state decodes.
//
// Notes on behaviour
// - Cache-load path works only while instruction register holds 00111.
// - Memory line fills never reach mini cache; only this loader writes it.
// - Capture leaves capture shift register contents arbitrary; host ignores them.
// - Every function and data word is one 33-bit packet shifted in.
// - Update copies to holding reg, crosses to core, loads core shift reg.
// - Low three bits select: line invalidate, mini flush, main write, mini write.
// - Line invalidate clears the line holding the address, no data packets.
// - Mini flush clears whole mini cache only; main cache and branch buffer kept.
// - Invalidates use one packet; line writes use command plus eight data.
// - Command bits 32 down to 6 carry address bits 31 down to 5.
// - Data packet: word in low 32 bits, parity in bit 32.
// - Cache-load mode keeps both caches valid across processor reset.
// - Halt mode spares only mini cache at reset; main cache still cleared.
// - Test reset forces identity instruction and clears both protecting modes.
// - Under debug-select instruction, reset-hold follows debug shift bit 1.
// - Reset pin released while hold set keeps core in internal reset.
// - Clearing hold releases reset; core starts at address zero.
`timescale 1ns/1ps
`include "jicl_params.svh"

module jicl_top (
	input  wire logic                     mclk_i,
	input  wire logic                     srst_i,
	input  wire logic                     tck_i,
	input  wire logic                     test_rst_i,
	input  wire logic                     tdi_i,
	input  wire logic                     capture_dr_i,
	input  wire logic                     shift_dr_i,
	input  wire logic                     update_dr_i,
	input  wire logic                     ir_update_i,
	input  wire logic [`JICL_IR_W-1:0]    ir_value_i,
	input  wire logic                     dbg_hold_bit_i,
	input  wire logic                     dbg_halt_bit_i,
	input  wire logic                     reset_pin_n_i,
	output logic                          tdo_o,
	output logic                          core_rst_o,
	output logic [`JICL_WORD_W-1:0]       reset_vector_o,
	output logic                          ic_main_rst_inval_o,
	output logic                          ic_mini_rst_inval_o,
	output logic                          ic_inval_line_o,
	output logic                          ic_mini_flush_o,
	output logic                          ic_wr_main_o,
	output logic                          ic_wr_mini_o,
	output logic [`JICL_ADDR_W-1:0]       ic_line_addr_o,
	output logic [`JICL_WIDX_W-1:0]       ic_wr_word_o,
	output logic [`JICL_WORD_W-1:0]       ic_wr_data_o,
	output logic                          ic_wr_par_o,
	output logic                          load_busy_o
);
	localparam int DRAIN_CYC = `JICL_DRAIN_CYC;

	jicl_pkg::jicl_core_st_t r_reg;
	jicl_pkg::jicl_core_st_t r_next;

	logic                       t_load_mode;
	logic                       t_reset_hold;
	logic                       t_halt_mode;
	logic                       t_upd_tgl;
	logic [`JICL_PKT_MSB:0]     t_hold_data;
	logic [`JICL_X_W-1:0]       x_in;
	logic [`JICL_X_W-1:0]       x_rst;
	logic [`JICL_X_W-1:0]       x_out;
	logic                       load_mode_s;
	logic                       reset_hold_s;
	logic                       halt_mode_s;
	logic                       pin_rst_n_s;
	logic                       new_pkt;
	logic                       rst_req;
	logic [`JICL_FN_MSB:0]      fn_code;

	function automatic logic [`JICL_ADDR_W-1:0] pkt_line_va(
		input logic [`JICL_PKT_MSB:0] pkt
	);
		pkt_line_va = pkt[`JICL_PKT_MSB:`JICL_ADDR_LSB];
	endfunction : pkt_line_va

	jicl_tck_side u_tck (
		.tck_i          (tck_i),
		.test_rst_i     (test_rst_i),
		.tdi_i          (tdi_i),
		.capture_dr_i   (capture_dr_i),
		.shift_dr_i     (shift_dr_i),
		.update_dr_i    (update_dr_i),
		.ir_update_i    (ir_update_i),
		.ir_value_i     (ir_value_i),
		.dbg_hold_bit_i (dbg_hold_bit_i),
		.dbg_halt_bit_i (dbg_halt_bit_i),
		.tdo_o          (tdo_o),
		.load_mode_o    (t_load_mode),
		.reset_hold_o   (t_reset_hold),
		.halt_mode_o    (t_halt_mode),
		.upd_tgl_o      (t_upd_tgl),
		.hold_data_o    (t_hold_data)
	);

	// Toggle announces a packet; holding data is steady by then
	always_comb begin
		x_in                 = '0;
		x_in[`JICL_X_TGL]    = t_upd_tgl;
		x_in[`JICL_X_MODE]   = t_load_mode;
		x_in[`JICL_X_HOLD]   = t_reset_hold;
		x_in[`JICL_X_HALT]   = t_halt_mode;
		x_in[`JICL_X_PIN_N]  = reset_pin_n_i;
		x_rst                = '0;
	end

	jicl_sync #(
		.WIDTH (`JICL_X_W)
	) u_sync (
		.clk_i     (mclk_i),
		.rst_i     (srst_i),
		.d_i       (x_in),
		.rst_val_i (x_rst),
		.q_o       (x_out)
	);

	assign load_mode_s  = x_out[`JICL_X_MODE];
	assign reset_hold_s = x_out[`JICL_X_HOLD];
	assign halt_mode_s  = x_out[`JICL_X_HALT];
	assign pin_rst_n_s  = x_out[`JICL_X_PIN_N];
	assign new_pkt      = x_out[`JICL_X_TGL] ^ r_reg.tgl_d;
	assign rst_req      = !pin_rst_n_s || reset_hold_s;
	assign fn_code      = r_reg.core_sr[`JICL_FN_MSB:0];

	always_comb begin
		r_next            = r_reg;
		r_next.tgl_d      = x_out[`JICL_X_TGL];
		r_next.inval_line = 1'b0;
		r_next.mini_flush = 1'b0;
		r_next.wr_main    = 1'b0;
		r_next.wr_mini    = 1'b0;

		case (r_reg.state)
			jicl_pkg::JICL_IDLE: begin
				if (new_pkt && load_mode_s) begin
					r_next.core_sr = t_hold_data;
					r_next.state   = jicl_pkg::JICL_ISSUE;
				end
			end
			jicl_pkg::JICL_ISSUE: begin
				r_next.state = jicl_pkg::JICL_IDLE;
				if (r_reg.expect_data) begin
					// Only this path may write the mini cache
					r_next.wr_main  = !r_reg.mini_sel;
					r_next.wr_mini  = r_reg.mini_sel;
					r_next.wr_word  = r_reg.word_idx;
					r_next.wr_data  = r_reg.core_sr[`JICL_WORD_W-1:0];
					r_next.wr_par   = r_reg.core_sr[`JICL_PAR_BIT];
					r_next.word_idx = r_reg.word_idx + 3'h1;
					if (r_reg.word_idx == `JICL_LAST_WORD) begin
						r_next.expect_data = 1'b0;
					end
				end else begin
					case (fn_code)
						`JICL_FN_INV_LINE: begin
							r_next.inval_line = 1'b1;
							r_next.line_addr  = pkt_line_va(r_reg.core_sr);
						end
						`JICL_FN_MINI_FLUSH: begin
							r_next.mini_flush = 1'b1;
						end
						`JICL_FN_MAIN_WR,
						`JICL_FN_MINI_WR: begin
							r_next.expect_data = 1'b1;
							r_next.word_idx    = '0;
							r_next.mini_sel    = (fn_code == `JICL_FN_MINI_WR);
							r_next.line_addr   = pkt_line_va(r_reg.core_sr);
						end
						default: begin
							r_next.expect_data = 1'b0;
						end
					endcase
				end
			end
			default: begin
				r_next.state = jicl_pkg::JICL_IDLE;
			end
		endcase

		// Leaving cache-load mode abandons any half-sent line
		if (!load_mode_s) begin
			r_next.state       = jicl_pkg::JICL_IDLE;
			r_next.expect_data = 1'b0;
			r_next.inval_line  = 1'b0;
			r_next.mini_flush  = 1'b0;
			r_next.wr_main     = 1'b0;
			r_next.wr_mini     = 1'b0;
		end

		r_next.core_rst   = rst_req;
		r_next.main_inval = rst_req && !load_mode_s;
		r_next.mini_inval = rst_req && !load_mode_s && !halt_mode_s;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			r_reg            <= '0;
			r_reg.core_rst   <= 1'b1;
			r_reg.main_inval <= 1'b1;
			r_reg.mini_inval <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign core_rst_o          = r_reg.core_rst;
	assign reset_vector_o      = `JICL_RESET_VECTOR;
	assign ic_main_rst_inval_o = r_reg.main_inval;
	assign ic_mini_rst_inval_o = r_reg.mini_inval;
	assign ic_inval_line_o     = r_reg.inval_line;
	assign ic_mini_flush_o     = r_reg.mini_flush;
	assign ic_wr_main_o        = r_reg.wr_main;
	assign ic_wr_mini_o        = r_reg.wr_mini;
	assign ic_line_addr_o      = r_reg.line_addr;
	assign ic_wr_word_o        = r_reg.wr_word;
	assign ic_wr_data_o        = r_reg.wr_data;
	assign ic_wr_par_o         = r_reg.wr_par;
	assign load_busy_o         = (r_reg.state == jicl_pkg::JICL_ISSUE) || r_reg.expect_data;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_accept;
		(r_reg.state == jicl_pkg::JICL_IDLE) && new_pkt && load_mode_s;
	endsequence

	sequence s_issue_then_idle;
		(r_reg.state == jicl_pkg::JICL_ISSUE) ##1 (r_reg.state == jicl_pkg::JICL_IDLE);
	endsequence

	sequence s_cmd_issue(logic [2:0] code);
		(r_reg.state == jicl_pkg::JICL_ISSUE) && !r_reg.expect_data
			&& (fn_code == code) && load_mode_s;
	endsequence

	a_drain_bound : assert property (
		s_accept |=> s_issue_then_idle ##[0:DRAIN_CYC] (r_reg.state == jicl_pkg::JICL_IDLE))
		else $error("packet not drained in time");

	a_mode_gate : assert property (
		(ic_inval_line_o || ic_mini_flush_o || ic_wr_main_o || ic_wr_mini_o)
			|-> $past(load_mode_s))
		else $error("cache strobe outside cache-load mode");

	a_line_inval : assert property (
		s_cmd_issue(`JICL_FN_INV_LINE) |=> ic_inval_line_o && !ic_wr_main_o
			&& (ic_line_addr_o == $past(r_reg.core_sr[`JICL_PKT_MSB:`JICL_ADDR_LSB])))
		else $error("line invalidate wrong");

	a_mini_flush : assert property (
		s_cmd_issue(`JICL_FN_MINI_FLUSH) |=> ic_mini_flush_o && !ic_inval_line_o
			&& !ic_wr_main_o && !r_reg.expect_data)
		else $error("mini flush wrong");

	a_reserved_noop : assert property (
		(r_reg.state == jicl_pkg::JICL_ISSUE && !r_reg.expect_data && fn_code[2])
			|=> !(ic_inval_line_o || ic_mini_flush_o || ic_wr_main_o || ic_wr_mini_o)
			&& !r_reg.expect_data)
		else $error("reserved code had an effect");

	a_line_length : assert property (
		(ic_wr_main_o || ic_wr_mini_o) && (ic_wr_word_o == `JICL_LAST_WORD)
			|-> !r_reg.expect_data)
		else $error("line did not end after eight words");

	a_data_parity : assert property (
		(r_reg.state == jicl_pkg::JICL_ISSUE && r_reg.expect_data && load_mode_s)
			|=> (ic_wr_par_o == $past(r_reg.core_sr[`JICL_PAR_BIT]))
			&& (ic_wr_data_o == $past(r_reg.core_sr[`JICL_WORD_W-1:0])))
		else $error("data word or parity misplaced");

	a_mini_only_loader : assert property (
		ic_wr_mini_o |-> !ic_wr_main_o && $past(r_reg.mini_sel) && $past(r_reg.expect_data))
		else $error("mini write without mini line command");

	a_load_spares : assert property (
		$past(load_mode_s) |-> !ic_main_rst_inval_o && !ic_mini_rst_inval_o)
		else $error("cache-load mode did not protect caches");

	a_halt_spares : assert property (
		($past(halt_mode_s) && !$past(load_mode_s) && core_rst_o)
			|-> ic_main_rst_inval_o && !ic_mini_rst_inval_o)
		else $error("halt mode protection wrong");

	a_hold_keeps : assert property (
		$past(reset_hold_s) |-> core_rst_o)
		else $error("core left reset while hold set");

	a_hold_release : assert property (
		($past(pin_rst_n_s) && !$past(reset_hold_s)) |-> !core_rst_o)
		else $error("core held in reset after release");

endmodule : jicl_top

/* tb/jicl_host.sv */
// Debug host model: drives the test port state decodes and serial data.
// Assumes the loader's test-clock side on the far side; tck runs only in tasks.
`timescale 1ns/1ps
`include "jicl_params.svh"

module jicl_host (
	output logic                  tck_o,
	output logic                  test_rst_o,
	output logic                  tdi_o,
	output logic                  capture_dr_o,
	output logic                  shift_dr_o,
	output logic                  update_dr_o,
	output logic                  ir_update_o,
	output logic [`JICL_IR_W-1:0] ir_value_o,
	output logic                  dbg_hold_o,
	output logic                  dbg_halt_o
);
	initial begin
		tck_o = 1'b0;
		test_rst_o = 1'b0;
		tdi_o = 1'b0;
		capture_dr_o = 1'b0;
		shift_dr_o = 1'b0;
		update_dr_o = 1'b0;
		ir_update_o = 1'b0;
		ir_value_o = `JICL_IR_IDCODE;
		dbg_hold_o = 1'b0;
		dbg_halt_o = 1'b0;
	end

	// One test clock; signals change only after its falling edge
	task automatic tick();
		#62.5 tck_o = ~tck_o;
		#62.5 tck_o = ~tck_o;
	endtask : tick

	// Idle clocks; data line wanders so a stale value is never trusted
	task automatic idle(input int n);
		repeat (n) begin
			tdi_o = ~tdi_o;
			tick();
		end
	endtask : idle

	task automatic ir_load(input logic [`JICL_IR_W-1:0] v);
		ir_value_o = v;
		ir_update_o = 1'b1;
		tick();
		ir_update_o = 1'b0;
	endtask : ir_load

	// Scan under debug select: hold and halt bits taken at update
	task automatic dbg_write(input logic hold, input logic halt);
		dbg_hold_o = hold;
		dbg_halt_o = halt;
		update_dr_o = 1'b1;
		tick();
		update_dr_o = 1'b0;
	endtask : dbg_write

	// Capture (contents ignored), 33 shifts LSB first, then update
	task automatic send_pkt(input logic [`JICL_PKT_MSB:0] p);
		capture_dr_o = 1'b1;
		tick();
		capture_dr_o = 1'b0;
		shift_dr_o = 1'b1;
		for (int i = 0; i < `JICL_PKT_W; i++) begin
			tdi_o = p[i];
			tick();
		end
		shift_dr_o = 1'b0;
		update_dr_o = 1'b1;
		tick();
		update_dr_o = 1'b0;
	endtask : send_pkt

	task automatic test_reset();
		test_rst_o = ~test_rst_o;
		tick();
		tick();
		test_rst_o = ~test_rst_o;
	endtask : test_reset
endmodule : jicl_host

/* tb/testbench.sv */
// Self-checking bench for the test-port cache loader with a host model.
// Assumes the core clock at 10 MHz and host test clock at 8 MHz.
`timescale 1ns/1ps
`include "jicl_params.svh"

module testbench;
	logic                  mclk_i, srst_i, reset_pin_n_i;
	logic                  tck, trst, tdi, cap, shf, upd, irup, hold, halt;
	logic [`JICL_IR_W-1:0] irv;
	logic                  core_rst, main_inv, mini_inv, inv_line, flush, wr_main, wr_mini;
	logic                  par, busy, tdo;
	logic [31:0]           vec, wdata;
	logic [26:0]           laddr;
	logic [2:0]            widx;
	int                    bad_count, checked;
	logic [66:0]           ev_q[$];

	jicl_host i_jicl_host (.tck_o(tck), .test_rst_o(trst), .tdi_o(tdi), .capture_dr_o(cap),
		.shift_dr_o(shf), .update_dr_o(upd), .ir_update_o(irup), .ir_value_o(irv),
		.dbg_hold_o(hold), .dbg_halt_o(halt));

	jicl_top i_jicl_top (.mclk_i(mclk_i), .srst_i(srst_i), .tck_i(tck), .test_rst_i(trst),
		.tdi_i(tdi), .capture_dr_i(cap), .shift_dr_i(shf), .update_dr_i(upd),
		.ir_update_i(irup), .ir_value_i(irv), .dbg_hold_bit_i(hold), .dbg_halt_bit_i(halt),
		.reset_pin_n_i(reset_pin_n_i), .tdo_o(tdo), .core_rst_o(core_rst), .reset_vector_o(vec),
		.ic_main_rst_inval_o(main_inv), .ic_mini_rst_inval_o(mini_inv),
		.ic_inval_line_o(inv_line), .ic_mini_flush_o(flush), .ic_wr_main_o(wr_main),
		.ic_wr_mini_o(wr_mini), .ic_line_addr_o(laddr), .ic_wr_word_o(widx),
		.ic_wr_data_o(wdata), .ic_wr_par_o(par), .load_busy_o(busy));

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// Event: {line inval, flush, main write, mini write}, addr, word, data, parity
	function automatic logic [66:0] mk(input logic [3:0] k, input logic [26:0] a,
		input logic [2:0] w, input logic [31:0] d, input logic p);
		return {k, a, w, d, p};
	endfunction : mk

	// Cache strobe recorder, sampled mid-cycle
	always @(negedge mclk_i) begin
		if (inv_line | flush | wr_main | wr_mini)
			ev_q.push_back(mk({inv_line, flush, wr_main, wr_mini}, flush ? 27'h0 : laddr,
				(wr_main | wr_mini) ? widx : 3'h0, (wr_main | wr_mini) ? wdata : 32'h0,
				(wr_main | wr_mini) ? par : 1'b0));
	end

	task automatic chk_bit(input string name, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", name, e, g);
		end
	endtask : chk_bit

	task automatic chk_ev(input logic [66:0] e);
		logic [66:0] g;
		checked++;
		g = (ev_q.size() > 0) ? ev_q.pop_front() : 67'h0;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH cache event expected %h seen %h", e, g);
		end
	endtask : chk_ev

	// Reset pin changes only at a core clock falling edge
	task automatic set_pin(input logic lvl);
		@(negedge mclk_i);
		reset_pin_n_i = lvl;
	endtask : set_pin

	task automatic sc_cold();
		i_jicl_host.test_reset();
		i_jicl_host.idle(4);
		chk_bit("main inval cold", 1'b1, main_inv);
		i_jicl_host.ir_load(`JICL_IR_DBG_SEL);
		i_jicl_host.dbg_write(1'b1, 1'b1);
		i_jicl_host.idle(4);
		chk_bit("mini inval halt", 1'b0, mini_inv);
		chk_bit("main inval halt", 1'b1, main_inv);
		set_pin(1'b1);
		repeat (10) @(negedge mclk_i);
		chk_bit("core reset held", 1'b1, core_rst);
		i_jicl_host.idle(2030);
		i_jicl_host.ir_load(`JICL_IR_CACHE_LOAD);
		i_jicl_host.idle(4);
		chk_bit("main inval load mode", 1'b0, main_inv);
		chk_bit("mini inval load mode", 1'b0, mini_inv);
	endtask : sc_cold

	task automatic sc_line(input logic [2:0] fn, input logic [26:0] a);
		logic [31:0] d;
		ev_q.delete();
		i_jicl_host.send_pkt({a, 3'h0, fn});
		for (int k = 0; k < 8; k++) begin
			d = {a[15:0], 13'h0, 3'(k)};
			i_jicl_host.send_pkt({^d, d});
		end
		i_jicl_host.idle(15);
		for (int k = 0; k < 8; k++) begin
			d = {a[15:0], 13'h0, 3'(k)};
			chk_ev(mk((fn == `JICL_FN_MAIN_WR) ? 4'h2 : 4'h1, a, 3'(k), d, ^d));
		end
		chk_bit("no extra event", 1'b1, ev_q.size() == 0);
		chk_bit("busy after drain", 1'b0, busy);
		chk_bit("serial out", d[0], tdo);
	endtask : sc_line

	task automatic sc_single(input logic [2:0] fn, input logic [26:0] a, input logic [3:0] k);
		ev_q.delete();
		i_jicl_host.send_pkt({a, 3'h0, fn});
		i_jicl_host.idle(15);
		if (k != 4'h0)
			chk_ev(mk(k, (k == 4'h4) ? 27'h0 : a, 3'h0, 32'h0, 1'b0));
		chk_bit("single packet only", 1'b1, ev_q.size() == 0);
		chk_bit("serial out", fn[0], tdo);
	endtask : sc_single

	task automatic sc_refuse();
		i_jicl_host.ir_load(`JICL_IR_DBG_SEL);
		sc_single(`JICL_FN_MINI_FLUSH, 27'h0, 4'h0);
	endtask : sc_refuse

	task automatic sc_release();
		i_jicl_host.dbg_write(1'b0, 1'b1);
		i_jicl_host.idle(4);
		chk_bit("core released", 1'b0, core_rst);
		chk_bit("vector zero", 1'b1, vec === `JICL_RESET_VECTOR);
		i_jicl_host.test_reset();
		set_pin(1'b0);
		i_jicl_host.idle(4);
		chk_bit("core reset again", 1'b1, core_rst);
		chk_bit("main inval trst", 1'b1, main_inv);
		chk_bit("mini inval trst", 1'b1, mini_inv);
	endtask : sc_release

	task automatic end_sim();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	initial begin
		#2000000;
		bad_count++;
		$display("MISMATCH run length expected finish seen hang");
		end_sim();
	end

	initial begin
		bad_count = 0;
		checked = 0;
		srst_i = 1'b1;
		reset_pin_n_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		srst_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		sc_cold();
		sc_line(`JICL_FN_MAIN_WR, 27'h0000123);
		sc_line(`JICL_FN_MINI_WR, 27'h7FFFFFF);
		sc_single(`JICL_FN_INV_LINE, 27'h0000123, 4'h8);
		for (int c = 4; c < 8; c++)
			sc_single(3'(c), 27'h0000040, 4'h0);
		sc_single(`JICL_FN_MINI_FLUSH, 27'h5555555, 4'h4);
		sc_refuse();
		sc_release();
		end_sim();
	end
endmodule : testbench
